// ---- rtl/ecfa_pkg.sv ----
// Constants, carriers and state layout of the enhanced-controller configuration bank.
// Assumes configuration accesses arrive as aligned dwords with byte enables, on the system clock.
package ecfa_pkg;

  // ----------------------------------------------------------------
  // Configuration offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_CAP_PTR_ADDR  = 8'h34;
  localparam logic [7:0] CFG_RELEASE_ADDR  = 8'h60;
  localparam logic [7:0] CFG_FRAME_ADDR    = 8'h61;
  localparam logic [7:0] CFG_WAKE_ADDR     = 8'h62;
  localparam logic [7:0] CFG_PM_BASE_ADDR  = 8'hDC;

  // Offsets inside the power management structure, from its base.
  localparam logic [2:0] PM_ID_OFS         = 3'h0;
  localparam logic [2:0] PM_NEXT_OFS       = 3'h1;
  localparam logic [2:0] PM_CAPS_OFS       = 3'h2;
  localparam logic [2:0] PM_CSR_OFS        = 3'h4;
  localparam logic [2:0] PM_BSE_OFS        = 3'h6;
  localparam logic [2:0] PM_DATA_OFS       = 3'h7;

  // ----------------------------------------------------------------
  // Fixed values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RELEASE_VAL      = 8'h20;
  localparam logic [7:0]  FRAME_ADJ_RST    = 8'h20;
  localparam logic [15:0] WAKE_MASK_RST    = 16'h0007;
  localparam logic [7:0]  POWER_CAPABILITY_IDENTIFIER_VAL       = 8'h01;
  localparam logic [7:0]  NEXT_PTR_VAL     = 8'h00;
  localparam logic [7:0]  CAP_PTR_VAL      = 8'hDC;

  // Field of the frame-length register.
  localparam int          FRAME_ADJ_LSB    = 0;
  localparam int          FRAME_ADJ_W      = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          UFRAME_BASE_PERIODS = 59488;
  localparam int          UFRAME_STEP_BITS    = 16;
  localparam int          SOF_CLK_MHZ         = 480;
  localparam int          SYS_CLK_MHZ         = 50;
  localparam int          ACC_W               = 23;
  localparam int          UFRAME_IDX_W        = 14;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } ecfa_cfg_req_t;

  typedef struct packed {
    logic        rvalid;
    logic [31:0] rdata;
  } ecfa_cfg_rsp_t;

  typedef struct packed {
    logic [7:0]              frame_adj;
    logic [15:0]             wake_mask;
    ecfa_cfg_rsp_t           rsp;
    logic [ACC_W-1:0]        len_scaled;
    logic [ACC_W-1:0]        acc;
    logic                    sof;
    logic [UFRAME_IDX_W-1:0] uframe_idx;
  } ecfa_state_t;

endpackage

// ---- rtl/ecfa_top.sv ----
// Configuration bank of the enhanced controller and the microframe (SOF) timer it steers.
// Assumes a configuration master on the same clock; one request at most per cycle.
`timescale 1ns/1ps

module ecfa_top
  import ecfa_pkg::*;
#(
  parameter int UFRAME_BASE = UFRAME_BASE_PERIODS,
  parameter int STEP_BITS   = UFRAME_STEP_BITS,
  parameter int SOF_MHZ     = SOF_CLK_MHZ,
  parameter int SYS_MHZ     = SYS_CLK_MHZ
) (
  // Clock, reset and enable
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    ce,
  // Configuration access
  input  wire ecfa_cfg_req_t           cfg_req,
  output ecfa_cfg_rsp_t                cfg_rsp,
  // Microframe timer
  output logic                         sof_pulse,
  output logic [UFRAME_IDX_W-1:0]      uframe_index
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Dword hit: configuration cycles address whole dwords.
  function automatic logic dw_hit(input logic [7:0] addr, input logic [7:0] base);
    dw_hit = (addr[7:2] == base[7:2]);
  endfunction

  // Byte lane of a byte offset inside its dword.
  function automatic int lane(input logic [7:0] addr);
    lane = 8 * int'(addr[1:0]);
  endfunction

  // Microframe length in sys-clock-scaled bit times. The counter runs at the SOF
  // rate in spirit: each system cycle credits SOF_MHZ, a microframe costs length*SYS_MHZ,
  // so the average period is exact without a second clock domain.
  function automatic logic [ACC_W-1:0] len_of(input logic [7:0] adj);
    int periods;
    periods = UFRAME_BASE + STEP_BITS * int'(adj[FRAME_ADJ_LSB +: FRAME_ADJ_W]);
    len_of  = ACC_W'(periods * SYS_MHZ);
  endfunction

  localparam logic [ACC_W-1:0] SOF_CREDIT = ACC_W'(SOF_MHZ);
  localparam logic [ACC_W-1:0] LEN_RST    = ACC_W'((UFRAME_BASE + STEP_BITS * int'(FRAME_ADJ_RST[5:0])) * SYS_MHZ);

  localparam ecfa_state_t ST_RST = '{
    frame_adj  : FRAME_ADJ_RST,
    wake_mask  : WAKE_MASK_RST,
    rsp        : '0,
    len_scaled : LEN_RST,
    acc        : '0,
    sof        : 1'b0,
    uframe_idx : '0
  };

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ecfa_state_t st_reg;
  ecfa_state_t st_next;

  logic [ACC_W-1:0] acc_sum;
  logic [31:0]      rd_word;
  logic             ehci_hit;

  always_comb begin
    st_next  = st_reg;
    acc_sum  = st_reg.acc + SOF_CREDIT;
    rd_word  = 32'h0000_0000;
    ehci_hit = dw_hit(cfg_req.addr, CFG_RELEASE_ADDR);

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Unmapped dwords, and the power fields left out here, read as zero.
    if (ehci_hit) begin
      rd_word[lane(CFG_RELEASE_ADDR) +: 8] = RELEASE_VAL;
      rd_word[lane(CFG_FRAME_ADDR) +: 8]   = st_reg.frame_adj;
      rd_word[lane(CFG_WAKE_ADDR) +: 16]   = st_reg.wake_mask;
    end else if (dw_hit(cfg_req.addr, CFG_CAP_PTR_ADDR)) begin
      rd_word[lane(CFG_CAP_PTR_ADDR) +: 8] = CAP_PTR_VAL;
    end else if (dw_hit(cfg_req.addr, CFG_PM_BASE_ADDR)) begin
      // Single power entry; no other dword carries the identifier.
      rd_word[8 * int'(PM_ID_OFS) +: 8]    = POWER_CAPABILITY_IDENTIFIER_VAL;
      rd_word[8 * int'(PM_NEXT_OFS) +: 8]  = NEXT_PTR_VAL;
    end
    st_next.rsp.rvalid = cfg_req.rd;
    st_next.rsp.rdata  = cfg_req.rd ? rd_word : 32'h0000_0000;

    // ----------------------------------------------------------------
    // Write path
    // ----------------------------------------------------------------
    // Reserved bits 7:6 are stored as written; software keeps them zero.
    if (cfg_req.wr && ehci_hit) begin
      if (cfg_req.be[CFG_FRAME_ADDR[1:0]]) begin
        st_next.frame_adj = cfg_req.wdata[lane(CFG_FRAME_ADDR) +: 8];
      end
      if (cfg_req.be[CFG_WAKE_ADDR[1:0]]) begin
        st_next.wake_mask[7:0] = cfg_req.wdata[lane(CFG_WAKE_ADDR) +: 8];
      end
      if (cfg_req.be[CFG_WAKE_ADDR[1:0] + 2'd1]) begin
        st_next.wake_mask[15:8] = cfg_req.wdata[lane(CFG_WAKE_ADDR) + 8 +: 8];
      end
    end

    // ----------------------------------------------------------------
    // Microframe timer
    // ----------------------------------------------------------------
    // The wake mask is deliberately not read here: it is storage only.
    st_next.sof = 1'b0;
    if (acc_sum >= st_reg.len_scaled) begin
      st_next.acc        = acc_sum - st_reg.len_scaled;
      st_next.sof        = 1'b1;
      st_next.uframe_idx = st_reg.uframe_idx + UFRAME_IDX_W'(1);
      // Reloading only here keeps a running microframe from being cut or stretched.
      st_next.len_scaled = len_of(st_reg.frame_adj);
    end else begin
      st_next.acc = acc_sum;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= ST_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_rsp      = st_reg.rsp;
  assign sof_pulse    = st_reg.sof;
  assign uframe_index = st_reg.uframe_idx;

endmodule // ecfa_top

// ---- tb/ecfa_host.sv ----
// Model of the configuration master in front of the bank.
// Assumes a read is answered exactly one cycle after it is taken.
`timescale 1ns/1ps
module ecfa_host
  import ecfa_pkg::*;
(
  // Clock and answer
  input  wire logic          clk,
  input  wire ecfa_cfg_rsp_t rsp,
  // Request
  output ecfa_cfg_req_t      req
);
  initial req = '0;
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [32:0] r);
    @(posedge clk);
    req <= '{rd: !w, wr: w, addr: a, be: be, wdata: d};
    @(posedge clk);
    // Idle fields show the inverse so that stale values are never relied on.
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~be, wdata: ~d};
    #1;
    r = rsp;
  endtask
endmodule // ecfa_host

// ---- tb/ecfa_properties.sv ----
// Checker for the configuration bank and its microframe timer.
// Assumes it is bound to ecfa_top and sees only that module's ports.
`timescale 1ns/1ps
module ecfa_chk
  import ecfa_pkg::*;
(
  // Watched ports
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic                    ce,
  input wire ecfa_cfg_req_t           cfg_req,
  input wire ecfa_cfg_rsp_t           cfg_rsp,
  input wire logic                    sof_pulse,
  input wire logic [UFRAME_IDX_W-1:0] uframe_index
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence rd_at(logic [5:0] dw);
    ce && cfg_req.rd && cfg_req.addr[7:2] == dw;
  endsequence
  AST_RD_LAT: assert property (ce && cfg_req.rd |=> cfg_rsp.rvalid) else $error("read unanswered");
  AST_RD_SPUR: assert property (cfg_rsp.rvalid |-> $past(ce && cfg_req.rd)) else $error("stray answer");
  AST_RD_IDLE: assert property (!cfg_rsp.rvalid |-> cfg_rsp.rdata == 32'h0) else $error("data outside answer");
  AST_RELEASE: assert property (rd_at(6'h18) |=> cfg_rsp.rdata[7:0] == 8'h20) else $error("release byte");
  AST_CAP_PTR: assert property (rd_at(6'h0D) |=> cfg_rsp.rdata == 32'hDC) else $error("pointer byte");
  AST_PM_HDR: assert property (rd_at(6'h37) |=> cfg_rsp.rdata[15:0] == 16'h0001) else $error("pm header");
  // Even the shortest microframe spans more than eight system cycles.
  AST_SOF_GAP: assert property (sof_pulse |=> !sof_pulse[*8]) else $error("microframe too short");
  AST_RST: assert property ($past(sys_rst) |-> uframe_index == '0 && !sof_pulse) else $error("timer reset");
endmodule // ecfa_chk

bind ecfa_top ecfa_chk chk_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
  .sof_pulse(sof_pulse), .uframe_index(uframe_index));

// ---- tb/tb_ecfa_top.sv ----
// Self-checking bench for the configuration bank and microframe timer.
// Assumes the base length is shortened to 100 bit times; twelve microframes then span 5/4 of a length.
`timescale 1ns/1ps
module tb_ecfa_top;
  import ecfa_pkg::*;
  logic                    clk;
  logic                    sys_rst;
  logic                    ce;
  ecfa_cfg_req_t           cfg_req;
  ecfa_cfg_rsp_t           cfg_rsp;
  logic                    sof_pulse;
  logic [UFRAME_IDX_W-1:0] uframe_index;
  logic [32:0]             r;
  logic [31:0]             seed;
  logic [31:0]             d;
  logic [15:0]             wake;
  logic [5:0]              fl;
  logic [UFRAME_IDX_W-1:0] held;
  int                      miscompares;
  int                      n_checks;
  int                      n;
  int                      total;
  logic [7:0]              addrs [4] = '{8'h60, 8'h34, 8'hDC, 8'h64};

  ecfa_top #(.UFRAME_BASE(100)) dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .sof_pulse(sof_pulse), .uframe_index(uframe_index));
  ecfa_host host_u (.clk(clk), .rsp(cfg_rsp), .req(cfg_req));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] expect_rd(input logic [7:0] a);
    case (a[7:2])
      6'h18: return {wake, 2'b00, fl, 8'h20};
      6'h0D: return 32'h0000_00DC;
      6'h37: return 32'h0000_0001;
      default: return 32'h0000_0000;
    endcase
  endfunction
  task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task read_all;
    foreach (addrs[i]) begin
      host_u.access(1'b0, addrs[i], 4'hF, 32'h0, r);
      check("read", r, {1'b1, expect_rd(addrs[i])});
    end
  endtask
  task next_sof;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sof_pulse !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      miscompares++;
      conclude();
    end
  endtask
  // Two boundaries are skipped so the new length is surely in force.
  task measure(input logic [5:0] f);
    next_sof();
    next_sof();
    held = uframe_index;
    total = 0;
    repeat (12) begin
      next_sof();
      total += n;
    end
    check("span", 33'(total), 33'((100 + 16 * f) * 5 / 4));
    check("index", 33'(uframe_index), 33'(held) + 33'd12);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    conclude();
  end
  initial begin
    sys_rst <= 1'b1;
    ce <= 1'b1;
    miscompares = 0;
    n_checks = 0;
    seed = 32'h172B1F79;
    wake = 16'h0007;
    fl = 6'd32;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    read_all();
    measure(fl);
    // The enable drops just after a boundary, so a frozen pulse never stands high.
    held = uframe_index;
    @(posedge clk);
    ce <= 1'b0;
    repeat (200) @(posedge clk);
    #1;
    check("frozen index", 33'(uframe_index), 33'(held));
    check("frozen pulse", 33'(sof_pulse), 33'h0);
    @(posedge clk);
    ce <= 1'b1;
    repeat (8) begin
      seed = lfsr(seed);
      d = {seed[31:16], 2'b00, seed[13:0]};
      host_u.access(1'b1, addrs[seed[15:14]], seed[3:0], d, r);
      check("write answer", r, 33'h0);
      if (seed[15:14] == 2'b00) begin
        if (seed[1]) fl = d[13:8];
        if (seed[2]) wake[7:0] = d[23:16];
        if (seed[3]) wake[15:8] = d[31:24];
      end
      read_all();
    end
    measure(fl);
    for (int k = 0; k < 2; k++) begin
      fl = k ? 6'd63 : 6'd0;
      host_u.access(1'b1, 8'h60, 4'b0010, {16'h0, 2'b00, fl, 8'h0}, r);
      measure(fl);
    end
    // A second reset in mid-run must restore every stored value.
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    wake = 16'h0007;
    fl = 6'd32;
    read_all();
    measure(fl);
    conclude();
  end
endmodule // tb_ecfa_top
